// >>> pkg/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_CNT_W 16
`define TCC_CNT_ZERO 16'h0000
`define TCC_CCR_RST 16'h0000
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3
`endif

// >>> pkg/tcc_pkg.sv
package tcc_pkg;
	typedef enum logic [3:0] {
		TCC_MODE_INTERVAL,
		TCC_MODE_EXT_EVENT,
		TCC_MODE_EXT_TRIG_PULSE,
		TCC_MODE_ONE_SHOT,
		TCC_MODE_PWM,
		TCC_MODE_FREE_RUN,
		TCC_MODE_PULSE_WIDTH,
		TCC_MODE_TRI_PWM,
		TCC_MODE_ENC_CMP
	} tcc_mode_t;

	typedef struct packed {
		tcc_mode_t   mode;
		logic        capture_sel;
		logic [1:0]  edge_sel;
		logic        out_enable;
	} tcc_cfg_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] wdata;
		logic        rd;
	} tcc_sw_t;
endpackage

// >>> hw/tcc_edge_det.sv
`timescale 1ns/100ps
`include "tcc_cfg.svh"
module tcc_edge_det
	import tcc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       pin_in,
	input  wire logic [1:0] edge_sel,
	output logic            edge_pulse
);
	// two-flop synchroniser, then one more stage for edge history
	logic sync1_reg;
	logic sync2_reg;
	logic hist_reg;
	logic sync1_next;
	logic sync2_next;
	logic hist_next;

	always_comb
	begin
		sync1_next = pin_in;
		sync2_next = sync1_reg;
		hist_next  = sync2_reg;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			hist_reg  <= 1'b0;
		end
		else
		begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			hist_reg  <= hist_next;
		end
	end

	always_comb
	begin
		case (edge_sel)
			`TCC_EDGE_RISE: edge_pulse = sync2_reg & ~hist_reg;
			`TCC_EDGE_FALL: edge_pulse = ~sync2_reg & hist_reg;
			`TCC_EDGE_BOTH: edge_pulse = sync2_reg ^ hist_reg;
			default:        edge_pulse = 1'b0;
		endcase
	end
endmodule

// >>> hw/tcc_channel.sv
`timescale 1ns/100ps
`include "tcc_cfg.svh"
// Notes on behaviour
// - compare-mode register writes are accepted while the counter runs; capture modes refuse them.
// - compare uses a shadow buffer loaded from the written value.
// - counter equal to shadow buffer raises the match interrupt pulse.
// - each match inverts the timer output when output is enabled.
// - dropping run enable keeps the compare value.
// - free-running capture stores the counter on a valid trigger edge.
// - pulse-width mode stores the counter and clears it to zero.
// - reads during capture return one consistent registered value.
// - dropping run enable clears the register when used for capture.
// - batch-write modes arm an update by the register write.
// - other compare modes load the shadow buffer immediately.
// - pulse-width mode is capture only; writes do not load compare.
module tcc_channel
	import tcc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        counter_run_enable,
	input  tcc_cfg_t         cfg,
	input  tcc_sw_t          sw,
	input  wire logic        period_end,
	input  wire logic        capture_trigger_input_one,
	output logic [15:0]      counter_value,
	output logic [15:0]      read_data,
	output logic             match_capture_irq_one,
	output logic             timer_output_one
);
	logic [15:0] counter_reg;
	logic [15:0] counter_next;
	logic [15:0] ccr_reg;
	logic [15:0] ccr_next;
	logic [15:0] compare_shadow_buffer;
	logic [15:0] shadow_next;
	logic        pending_reg;
	logic        pending_next;
	logic        irq_reg;
	logic        irq_next;
	logic        out_reg;
	logic        out_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        run_d_reg;
	logic        run_d_next;
	logic        trig_edge;
	logic        batch_mode;
	logic        capture_mode;
	logic        pw_mode;
	logic        match;
	logic        cap_event;

	tcc_edge_det u_edge (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.pin_in     (capture_trigger_input_one),
		.edge_sel   (cfg.edge_sel),
		.edge_pulse (trig_edge)
	);

	always_comb
	begin
		batch_mode   = (cfg.mode == TCC_MODE_EXT_TRIG_PULSE) ||
			(cfg.mode == TCC_MODE_PWM) || (cfg.mode == TCC_MODE_TRI_PWM);
		pw_mode      = (cfg.mode == TCC_MODE_PULSE_WIDTH);
		capture_mode = pw_mode || ((cfg.mode == TCC_MODE_FREE_RUN) && cfg.capture_sel);
		match        = counter_run_enable && !capture_mode &&
			(counter_reg == compare_shadow_buffer);
		cap_event    = counter_run_enable && capture_mode && trig_edge;
	end

	always_comb
	begin
		counter_next = counter_reg;
		ccr_next     = ccr_reg;
		shadow_next  = compare_shadow_buffer;
		pending_next = pending_reg;
		irq_next     = 1'b0;
		out_next     = out_reg;
		run_d_next   = counter_run_enable;
		rdata_next   = rdata_reg;
		if (counter_run_enable)
		begin
			if (period_end)
				counter_next = `TCC_CNT_ZERO;
			else
				counter_next = counter_reg + 16'h0001;
		end
		else
			counter_next = `TCC_CNT_ZERO;
		if (cap_event)
		begin
			ccr_next = counter_reg;
			irq_next = 1'b1;
			if (pw_mode)
				counter_next = `TCC_CNT_ZERO;
		end
		else if (sw.wr && !capture_mode)
		begin
			// accepted regardless of run state
			ccr_next = sw.wdata;
			if (batch_mode)
				pending_next = 1'b1;
			else
				shadow_next = sw.wdata;
		end
		// pulse-width mode ignores compare writes entirely
		if (batch_mode && pending_reg && (period_end || !counter_run_enable))
		begin
			shadow_next  = ccr_reg;
			pending_next = sw.wr;
		end
		if (match)
		begin
			irq_next = 1'b1;
			if (cfg.out_enable)
				out_next = ~out_reg;
		end
		// clear only for capture; compare value survives a stop
		if (!counter_run_enable && run_d_reg && capture_mode)
			ccr_next = `TCC_CCR_RST;
		// snapshot the whole word so a racing capture cannot tear it
		if (sw.rd)
			rdata_next = ccr_reg;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			counter_reg           <= `TCC_CNT_ZERO;
			ccr_reg               <= `TCC_CCR_RST;
			compare_shadow_buffer <= `TCC_CCR_RST;
			pending_reg           <= 1'b0;
			irq_reg               <= 1'b0;
			out_reg               <= 1'b0;
			run_d_reg             <= 1'b0;
			rdata_reg             <= `TCC_CCR_RST;
		end
		else
		begin
			counter_reg           <= counter_next;
			ccr_reg               <= ccr_next;
			compare_shadow_buffer <= shadow_next;
			pending_reg           <= pending_next;
			irq_reg               <= irq_next;
			out_reg               <= out_next;
			run_d_reg             <= run_d_next;
			rdata_reg             <= rdata_next;
		end
	end

	always_comb
	begin
		counter_value         = counter_reg;
		read_data             = rdata_reg;
		match_capture_irq_one = irq_reg;
		timer_output_one      = out_reg;
	end

	AST_MATCH_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
		match |=> match_capture_irq_one)
		else $error("match did not raise irq");

	AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!nrst)
		(match && cfg.out_enable) |=> (timer_output_one != $past(timer_output_one)))
		else $error("output not inverted on match");

	AST_NO_TOGGLE: assert property (@(posedge ref_clk) disable iff (!nrst)
		!match |=> $stable(timer_output_one))
		else $error("output changed without match");

	AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (!nrst)
		cap_event |=> (ccr_reg == $past(counter_reg)))
		else $error("capture value wrong");

	AST_PW_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cap_event && pw_mode) |=> (counter_reg == `TCC_CNT_ZERO))
		else $error("counter not cleared on pulse-width capture");

	AST_READ: assert property (@(posedge ref_clk) disable iff (!nrst)
		sw.rd |=> (read_data == $past(ccr_reg)))
		else $error("read value not consistent");

	AST_CAP_CLR: assert property (@(posedge ref_clk) disable iff (!nrst)
		($fell(counter_run_enable) && capture_mode) |=> (ccr_reg == `TCC_CCR_RST))
		else $error("capture register not cleared on stop");

	AST_KEEP_CMP: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!counter_run_enable && !capture_mode && !sw.wr) |=> $stable(ccr_reg))
		else $error("compare register changed on stop");

	AST_ANYTIME: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sw.wr && !capture_mode && !batch_mode)
		|=> (compare_shadow_buffer == $past(sw.wdata)))
		else $error("anytime write not applied");

	AST_BATCH_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sw.wr && batch_mode && !pending_reg && counter_run_enable && !period_end)
		|=> $stable(compare_shadow_buffer))
		else $error("batch write applied early");

	AST_WR_RUN: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sw.wr && counter_run_enable && !capture_mode)
		|=> (ccr_reg == $past(sw.wdata)))
		else $error("running write not accepted");

	AST_SHADOW_SRC: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!sw.wr && !pending_reg)
		|=> $stable(compare_shadow_buffer))
		else $error("shadow changed without a write");

	AST_IRQ_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
		match_capture_irq_one
		|-> ($past(match) || $past(cap_event)))
		else $error("irq without match or capture");

	AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!match && !cap_event)
		|=> !match_capture_irq_one)
		else $error("irq raised with no cause");

	AST_IRQ_STOPPED: assert property (@(posedge ref_clk) disable iff (!nrst)
		!counter_run_enable
		|=> !match_capture_irq_one)
		else $error("irq raised while stopped");

	AST_OUT_DISABLED: assert property (@(posedge ref_clk) disable iff (!nrst)
		!cfg.out_enable
		|=> $stable(timer_output_one))
		else $error("output toggled while disabled");

	AST_OUT_CAUSE: assert property (@(posedge ref_clk) disable iff (!nrst)
		$changed(timer_output_one)
		|-> ($past(match) && $past(cfg.out_enable)))
		else $error("output changed without enabled match");

	AST_STOP_SHADOW: assert property (@(posedge ref_clk) disable iff (!nrst)
		($fell(counter_run_enable) && !batch_mode && !sw.wr)
		|=> $stable(compare_shadow_buffer))
		else $error("shadow changed on stop");

	AST_STOP_CCR: assert property (@(posedge ref_clk) disable iff (!nrst)
		($fell(counter_run_enable) && !capture_mode && !sw.wr)
		|=> $stable(ccr_reg))
		else $error("compare value lost on stop");

	AST_CAP_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
		cap_event
		|=> match_capture_irq_one)
		else $error("capture did not raise irq");

	AST_CAP_NO_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cap_event && !pw_mode && !period_end)
		|=> (counter_value == $past(counter_reg) + 16'h0001))
		else $error("free-running capture disturbed the counter");

	AST_CAP_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		(capture_mode && counter_run_enable && !cap_event)
		|=> $stable(ccr_reg))
		else $error("capture register changed without edge");

	AST_PW_COUNT: assert property (@(posedge ref_clk) disable iff (!nrst)
		(pw_mode && counter_run_enable && !cap_event && !period_end)
		|=> (counter_value == $past(counter_reg) + 16'h0001))
		else $error("pulse-width counter did not advance");

	AST_READ_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
		!sw.rd
		|=> $stable(read_data))
		else $error("read data changed without a read");

	AST_CAP_CLR_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!counter_run_enable && !run_d_reg && !sw.wr)
		|=> $stable(ccr_reg))
		else $error("register changed while stopped");

	AST_BATCH_PEND: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sw.wr && batch_mode)
		|=> pending_reg)
		else $error("batch write not armed");

	AST_WR_REFUSED: assert property (@(posedge ref_clk) disable iff (!nrst)
		(sw.wr && capture_mode && counter_run_enable && !cap_event)
		|=> $stable(ccr_reg))
		else $error("write accepted in capture mode");

	AST_PW_SHADOW: assert property (@(posedge ref_clk) disable iff (!nrst)
		pw_mode
		|=> $stable(compare_shadow_buffer))
		else $error("shadow loaded in pulse-width mode");

	AST_BATCH_APPLY: assert property (@(posedge ref_clk) disable iff (!nrst)
		(batch_mode && pending_reg && period_end)
		|=> (compare_shadow_buffer == $past(ccr_reg)))
		else $error("batch value not applied at boundary");

	AST_BATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (!nrst)
		(batch_mode && pending_reg && period_end && !sw.wr)
		|=> !pending_reg)
		else $error("batch request left armed");

	AST_STOP_APPLY: assert property (@(posedge ref_clk) disable iff (!nrst)
		(batch_mode && pending_reg && !counter_run_enable)
		|=> (compare_shadow_buffer == $past(ccr_reg)))
		else $error("batch value not applied while stopped");
endmodule

// >>> tb/tcc_trig_src.sv
`timescale 1ns/100ps
module tcc_trig_src
(
	input  wire logic ref_clk,
	output logic      capture_trigger_input_one
);
	// pin idles low; it changes only just after an edge
	initial capture_trigger_input_one = 1'b0;
	// one high pulse; rise to rise spacing is hold plus one
	task automatic pulse(input int hold);
		@(posedge ref_clk);
		capture_trigger_input_one <= 1'b1;
		repeat (hold) @(posedge ref_clk);
		capture_trigger_input_one <= 1'b0;
	endtask
endmodule

// >>> tb/tb_tcc_channel.sv
`timescale 1ns/100ps
module tb_tcc_channel
	import tcc_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        nrst    = 1'b0;
	logic        counter_run_enable = 1'b0;
	tcc_cfg_t    cfg     = '0;
	tcc_sw_t     sw      = '0;
	logic        period_end = 1'b0;
	logic        trig;
	logic [15:0] counter_value;
	logic [15:0] read_data;
	logic        irq;
	logic        tout;
	int          n_fail = 0;
	int          tests_run = 0;

	always #12.5 ref_clk = ~ref_clk;

	tcc_trig_src u_src (.ref_clk(ref_clk), .capture_trigger_input_one(trig));
	tcc_channel uut (.ref_clk(ref_clk), .nrst(nrst), .counter_run_enable(counter_run_enable),
		.cfg(cfg), .sw(sw), .period_end(period_end), .capture_trigger_input_one(trig),
		.counter_value(counter_value), .read_data(read_data),
		.match_capture_irq_one(irq), .timer_output_one(tout));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wr(input logic [15:0] v);
		@(posedge ref_clk);
		sw <= '{wr: 1'b1, wdata: v, rd: 1'b0};
		@(posedge ref_clk);
		sw <= '0;
	endtask

	task automatic rd(output logic [15:0] v);
		@(posedge ref_clk);
		sw <= '{wr: 1'b0, wdata: 16'h0000, rd: 1'b1};
		@(posedge ref_clk);
		sw <= '0;
		@(posedge ref_clk);
		#1 v = read_data;
	endtask

	// waits for the next match or capture pulse, bounded
	task automatic wait_irq();
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(posedge ref_clk);
			#1;
			if (irq === 1'b1)
				break;
		end
		chk(16'(i < 300), 16'h0001);
	endtask

	task automatic set_run(input logic on, input tcc_cfg_t c);
		@(posedge ref_clk);
		counter_run_enable <= on;
		cfg <= c;
	endtask

	task automatic t_interval();
		logic [15:0] v;
		// load first: a zero count against the reset shadow would match at start
		wr(16'h0030);
		set_run(1'b1, '{mode: TCC_MODE_INTERVAL, capture_sel: 1'b0, edge_sel: 2'h0, out_enable: 1'b1});
		wr(16'h0014);
		wait_irq();
		chk(counter_value, 16'h0015);
		chk(16'(tout), 16'h0001);
		set_run(1'b0, cfg);
		rd(v);
		chk(v, 16'h0014);
		set_run(1'b1, '{mode: TCC_MODE_INTERVAL, capture_sel: 1'b0, edge_sel: 2'h0, out_enable: 1'b0});
		wait_irq();
		chk(16'(tout), 16'h0001);
		set_run(1'b0, cfg);
	endtask

	// new value must wait for the period boundary, old one still matches
	task automatic t_batch();
		set_run(1'b1, '{mode: TCC_MODE_PWM, capture_sel: 1'b0, edge_sel: 2'h0, out_enable: 1'b1});
		wr(16'h0005);
		wait_irq();
		chk(counter_value, 16'h0015);
		@(posedge ref_clk);
		period_end <= 1'b1;
		@(posedge ref_clk);
		period_end <= 1'b0;
		wait_irq();
		chk(counter_value, 16'h0006);
		set_run(1'b0, cfg);
	endtask

	task automatic t_capture();
		logic [15:0] v;
		set_run(1'b1, '{mode: TCC_MODE_PULSE_WIDTH, capture_sel: 1'b1, edge_sel: 2'h1,
			out_enable: 1'b0});
		u_src.pulse(9);
		u_src.pulse(3);
		tick(6);
		wr(16'h1234);
		rd(v);
		chk(v, 16'h0009);
		set_run(1'b1, '{mode: TCC_MODE_FREE_RUN, capture_sel: 1'b1, edge_sel: 2'h3,
			out_enable: 1'b0});
		fork
			u_src.pulse(4);
			wait_irq();
		join
		rd(v);
		chk(v, 16'h000F);
		set_run(1'b0, cfg);
		tick(2);
		rd(v);
		chk(v, 16'h0000);
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		tick(10);
		nrst <= 1'b1;
		t_interval();
		t_batch();
		t_capture();
		finish_test();
	end

	initial
	begin
		#(25 * 5000);
		n_fail++;
		finish_test();
	end
endmodule
